// ===== verilog/backlight_pkg.sv
// Purpose: Shared constants of the backlight dimming controller
// Assumes: 200 MHz core clock
// Notes: Register offsets are the host byte addresses
`default_nettype none
package backlight_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] BRT_ADDR = 8'h00;
  localparam logic [7:0] CTL_ADDR = 8'h01;
  localparam logic [7:0] CFG_ADDR = 8'h08;
  localparam logic [7:0] MASK_ADDR = 8'h09;
  localparam logic [7:0] PHASE_ADDR = 8'h0a;
  localparam logic [7:0] BRT_RESET = 8'hff;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h1f;
  localparam logic [5:0] MASK_RESET = 6'h3f;
  localparam logic [7:0] PHASE_RESET = 8'h80;
  // ==========================================================
  // Field positions
  localparam int CTL_ON_BIT = 0;
  localparam int CTL_SRC_BIT = 1;
  localparam int CTL_INTERP_BIT = 2;
  localparam int CFG_VSC_LSB = 0;
  localparam int CFG_FSW_BIT = 2;
  localparam int CFG_DIRECT_BIT = 7;
  localparam int PH_EQUAL_BIT = 7;
  localparam int NUM_CH = 6;
  // ==========================================================
  // Timing
  localparam int CLK_KHZ = 200000;
  localparam int BL_ON_MAX_US = 4000;
  localparam int BL_ON_CYCLES = BL_ON_MAX_US * (CLK_KHZ / 1000);
  localparam logic [11:0] DIM_PRESC = 12'd3922;
  localparam int DIRECT_TICK_KHZ = 12800;
  localparam int TICK_GCD_KHZ = 1600;
  localparam logic [6:0] TICK_ADD = 7'(DIRECT_TICK_KHZ / TICK_GCD_KHZ);
  localparam logic [6:0] TICK_MOD = 7'(CLK_KHZ / TICK_GCD_KHZ);
  localparam int DELAY_TAPS = 640;
  localparam int DUTY_WIN_LOG = 8;
endpackage
`default_nettype wire

// ===== verilog/dim_link_if.sv
// Purpose: Dimming settings from register bank to channel generator
// Assumes: Single core clock
// Notes: Plain signal bundle
`timescale 1ns/1ps
`default_nettype none
interface dim_link_if;
  logic on;
  logic direct;
  logic equal;
  logic [7:0] level;
  logic [6:0] ps;
  logic [5:0] active;
  modport drive (output on, direct, equal, level, ps, active);
  modport use_side (input on, direct, equal, level, ps, active);
endinterface // dim_link_if
`default_nettype wire

// ===== verilog/pulse_duty_meter.sv
// Purpose: Measures high fraction of the external pulse input
// Assumes: Input already synchronised
// Notes: Result in 1/255 steps, updated once per window
`timescale 1ns/1ps
`default_nettype none
module pulse_duty_meter #(
  parameter int WIN_LOG = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Pulse in, duty out
  input wire logic pulse_s,
  output logic [7:0] duty
);
  // Window of 255 sub-windows so a full-high input reads 255
  logic [WIN_LOG-1:0] sub_q;
  logic [7:0] slot_q;
  logic [WIN_LOG+7:0] hi_q;
  logic win_end;
  assign win_end = (slot_q == 8'd254) && (sub_q == '1);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_q <= '0;
      slot_q <= 8'h00;
      hi_q <= '0;
      duty <= 8'h00;
    end else begin
      sub_q <= sub_q + 1'b1;
      if (sub_q == '1) slot_q <= win_end ? 8'h00 : slot_q + 8'd1;
      hi_q <= win_end ? '0 : hi_q + (WIN_LOG+8)'(pulse_s);
      if (win_end) duty <= 8'(({1'b0, hi_q} + (WIN_LOG+9)'(pulse_s)) >> WIN_LOG);
    end
  end
endmodule // pulse_duty_meter
`default_nettype wire

// ===== verilog/channel_pwm_gen.sv
// Purpose: Per-channel phase-shifted dimming pulses
// Assumes: Direct input already synchronised
// Notes: Direct mode delays the input on a 12.8 MHz average tick
`timescale 1ns/1ps
`default_nettype none
module channel_pwm_gen
  import backlight_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Settings and direct input
  dim_link_if.use_side dl,
  input wire logic pulse_s,
  // Channel drive
  output logic [5:0] ch_drive
);
  function automatic logic [7:0] mod255(input logic [9:0] v);
    logic [9:0] r;
    r = v;
    if (r >= 10'd510) r = r - 10'd510;
    if (r >= 10'd255) r = r - 10'd255;
    return r[7:0];
  endfunction
  // ==========================================================
  // Dimming period base and direct delay line
  logic [11:0] presc_q;
  logic [7:0] step_q;
  logic [6:0] acc_q;
  // Eight bits so the sum cannot wrap below the modulus before the compare
  logic [7:0] acc_sum;
  logic [7:0] acc_wrap;
  logic tap_tick;
  assign acc_sum = {1'b0, acc_q} + {1'b0, TICK_ADD};
  assign acc_wrap = acc_sum - {1'b0, TICK_MOD};
  assign tap_tick = acc_sum >= {1'b0, TICK_MOD};
  logic [DELAY_TAPS-1:0] dly_q;
  logic [2:0] n_on;
  logic [7:0] eq_step;
  assign n_on = 3'($countones(dl.active));
  assign eq_step = (n_on <= 3'd1) ? 8'd255 : 8'(8'd255 / n_on);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= 12'h000;
      step_q <= 8'h00;
      acc_q <= 7'h00;
      dly_q <= '0;
    end else begin
      presc_q <= (presc_q == DIM_PRESC - 12'd1) ? 12'h000 : presc_q + 12'd1;
      if (presc_q == DIM_PRESC - 12'd1) step_q <= (step_q == 8'd254) ? 8'h00 : step_q + 8'd1;
      acc_q <= tap_tick ? acc_wrap[6:0] : acc_sum[6:0];
      if (tap_tick) dly_q <= {dly_q[DELAY_TAPS-2:0], pulse_s};
    end
  end
  // ==========================================================
  // One generator per channel
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam logic [5:0] BELOW = 6'((1 << i) - 1);
    logic [2:0] rank;
    logic [9:0] off;
    logic [7:0] pos;
    logic gen_hi;
    assign rank = 3'($countones(dl.active & BELOW));
    assign off = dl.equal ? 10'(rank * eq_step) : 10'(i * dl.ps);
    assign pos = mod255({2'b00, step_q} + 10'd255 - {2'b00, mod255(off)});
    assign gen_hi = pos < dl.level;
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) ch_drive[i] <= 1'b0;
      else ch_drive[i] <= dl.on & dl.active[i] & (dl.direct ? dly_q[off] : gen_hi);
    end
  end
endmodule // channel_pwm_gen
`default_nettype wire

// ===== verilog/backlight_dimming_control.sv
// Purpose: Host register bank and dimming control of a six-channel backlight
// Assumes: Byte reads and writes over a two-wire serial host link
// Notes: Slave address is a parameter; writes apply at end of transaction
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Code zero gives no pulses, codes 1 to 255 give n/255 duty
// - Brightness writes are taken only while host dimming is selected
// - Reading brightness returns the value last stored
// - All ones is full brightness, all zeros is minimum
// - Brightness resets to all ones
// - Control bits: on/off, source select, interpretation; off overrides all
// - Reserved control bits read back as written and do nothing
// - Backlight comes on within 4 ms; status set, channel readout nonzero
// - Writing off stops at once; status and channel readout go zero
// - Source select set: brightness follows external pulse duty
// - Source clear, interpretation set: host brightness only
// - Both clear: host brightness times external duty
// - Proportional mode leaves the brightness register untouched
// - Control register resets to zero: off, proportional mode
// - Direct bit makes channels follow external pulse; software sets 3..5
// - Frequency bit 0 selects 1.2 MHz, 1 selects 600 kHz
// - Two-bit short threshold; code zero disables short detection
// - Mask bits enable channels; readout shows healthy enabled channels
// - Equal-spread bit gives 360/N spacing, else the 7-bit setting
// - Setting step is a 1/255 dimming period, or 1/12.8 MHz when direct
module backlight_dimming_control
  import backlight_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2c,
  parameter int BL_ON_LIMIT = backlight_pkg::BL_ON_CYCLES,
  parameter int DUTY_LOG = backlight_pkg::DUTY_WIN_LOG
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Host serial link
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // External dimming pulse
  input wire logic external_pulse_input,
  // Channel status from the analog side
  input wire logic [5:0] ch_fault,
  input wire logic [5:0] ch_short,
  // Driver controls
  output logic [5:0] ch_drive,
  output logic boost_enable,
  output logic backlight_status_flag,
  output logic switching_freq_select,
  output logic [1:0] short_threshold_select
);
  import backlight_pkg::*;
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_AACK, S_REG, S_RACK, S_WDAT, S_WACK, S_RD, S_RDACK
  } link_state_type;

  // ==========================================================
  // Input synchronisers
  logic [14:0] sync_m_q;
  logic [14:0] sync_s_q;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_s;
  logic sda_s;
  logic pulse_s;
  logic [5:0] fault_s;
  logic [5:0] short_s;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_m_q <= 15'h7fff;
      sync_s_q <= 15'h7fff;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      sync_m_q <= {ch_short, ch_fault, external_pulse_input, sda_in, scl_in};
      sync_s_q <= sync_m_q;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end
  assign scl_s = sync_s_q[0];
  assign sda_s = sync_s_q[1];
  assign pulse_s = sync_s_q[2];
  assign fault_s = sync_s_q[8:3];
  assign short_s = sync_s_q[14:9];

  // ==========================================================
  // Link events
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ==========================================================
  // Serial byte engine
  link_state_type state_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic nack_q;
  logic sda_low_q;
  logic pend_q;
  logic [7:0] pend_addr_q;
  logic [7:0] pend_data_q;
  logic [7:0] rdata;
  logic byte_done;
  assign byte_done = scl_fall && (cnt_q == 4'd8);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (start_ev) begin
      state_q <= S_ADDR;
      cnt_q <= 4'h0;
      sda_low_q <= 1'b0;
    end else if (stop_ev) begin
      state_q <= S_IDLE;
      sda_low_q <= 1'b0;
    end else begin
      if (scl_rise) begin
        sh_q <= {sh_q[6:0], sda_s};
        cnt_q <= cnt_q + 4'd1;
        if (state_q == S_RDACK) nack_q <= sda_s;
      end
      case (state_q)
        S_ADDR: begin
          if (byte_done) begin
            state_q <= (sh_q[7:1] == DEV_ADDR) ? S_AACK : S_IDLE;
            sda_low_q <= (sh_q[7:1] == DEV_ADDR);
            rw_q <= sh_q[0];
          end
        end
        S_AACK: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            state_q <= rw_q ? S_RD : S_REG;
            sda_low_q <= rw_q & ~rdata[7];
            tx_q <= {rdata[6:0], 1'b0};
          end
        end
        S_REG: begin
          if (byte_done) begin
            ptr_q <= sh_q;
            state_q <= S_RACK;
            sda_low_q <= 1'b1;
          end
        end
        S_RACK, S_WACK: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            state_q <= S_WDAT;
            sda_low_q <= 1'b0;
          end
        end
        S_WDAT: begin
          if (byte_done) begin
            state_q <= S_WACK;
            sda_low_q <= 1'b1;
          end
        end
        S_RD: begin
          if (byte_done) begin
            state_q <= S_RDACK;
            sda_low_q <= 1'b0;
          end else if (scl_fall) begin
            sda_low_q <= ~tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        S_RDACK: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            state_q <= nack_q ? S_IDLE : S_RD;
            sda_low_q <= ~nack_q & ~rdata[7];
            tx_q <= {rdata[6:0], 1'b0};
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = sda_low_q;

  // Held write: a later data byte of the same transaction replaces it
  logic apply;
  assign apply = pend_q & (start_ev | stop_ev);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      pend_addr_q <= 8'h00;
      pend_data_q <= 8'h00;
    end else if (state_q == S_WDAT && byte_done && !start_ev && !stop_ev) begin
      pend_q <= 1'b1;
      pend_addr_q <= ptr_q;
      pend_data_q <= sh_q;
    end else if (apply) begin
      pend_q <= 1'b0;
    end
  end

  // ==========================================================
  // Register bank
  logic [7:0] brt_q;
  logic [7:0] ctl_q;
  logic [7:0] cfg_q;
  logic [5:0] mask_q;
  logic [7:0] ph_q;
  logic wr_brt;
  logic wr_ctl;
  logic wr_cfg;
  logic wr_mask;
  logic wr_ph;
  logic src_pulse;
  logic host_only;
  assign src_pulse = ctl_q[CTL_SRC_BIT];
  assign host_only = ~src_pulse & ctl_q[CTL_INTERP_BIT];
  // Host writes land in both host modes so proportional mode keeps them
  assign wr_brt = apply && pend_addr_q == BRT_ADDR && !src_pulse;
  assign wr_ctl = apply && pend_addr_q == CTL_ADDR;
  assign wr_cfg = apply && pend_addr_q == CFG_ADDR;
  assign wr_mask = apply && pend_addr_q == MASK_ADDR;
  assign wr_ph = apply && pend_addr_q == PHASE_ADDR;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      brt_q <= BRT_RESET;
      ctl_q <= CTL_RESET;
      cfg_q <= CFG_RESET;
      mask_q <= MASK_RESET;
      ph_q <= PHASE_RESET;
    end else begin
      if (wr_brt) brt_q <= pend_data_q;
      if (wr_ctl) ctl_q <= pend_data_q;
      if (wr_cfg) cfg_q <= pend_data_q;
      if (wr_mask) mask_q <= pend_data_q[5:0];
      if (wr_ph) ph_q <= pend_data_q;
    end
  end

  // ==========================================================
  // Backlight sequencing and channel health
  logic on_bit;
  logic [19:0] on_cnt_q;
  logic backlight_status_flag_q;
  logic [1:0] vsc;
  logic [5:0] health;
  assign on_bit = ctl_q[CTL_ON_BIT];
  assign vsc = cfg_q[CFG_VSC_LSB +: 2];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_cnt_q <= 20'h0_0000;
      backlight_status_flag_q <= 1'b0;
    end else if (!on_bit) begin
      on_cnt_q <= 20'h0_0000;
      backlight_status_flag_q <= 1'b0;
    end else if (!backlight_status_flag_q) begin
      on_cnt_q <= on_cnt_q + 20'd1;
      backlight_status_flag_q <= (on_cnt_q >= 20'(BL_ON_LIMIT - 1));
    end
  end
  // Short reports are ignored entirely when the threshold code is zero
  assign health = mask_q & ~fault_s & ~(short_s & {6{vsc != 2'b00}}) & {6{backlight_status_flag_q}};
  assign backlight_status_flag = backlight_status_flag_q;
  assign boost_enable = on_bit;
  assign switching_freq_select = cfg_q[CFG_FSW_BIT];
  assign short_threshold_select = vsc;

  // Read mux
  assign rdata = (ptr_q == BRT_ADDR) ? brt_q :
                 (ptr_q == CTL_ADDR) ? ctl_q :
                 (ptr_q == CFG_ADDR) ? cfg_q :
                 (ptr_q == MASK_ADDR) ? {2'b00, health} :
                 (ptr_q == PHASE_ADDR) ? ph_q : 8'h00;

  // ==========================================================
  // Dimming source
  logic [7:0] duty;
  logic [16:0] prod;
  logic [7:0] level;
  pulse_duty_meter #(.WIN_LOG(DUTY_LOG)) u_meter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pulse_s(pulse_s),
    .duty(duty)
  );
  // Rounded so full host code times full duty stays full
  assign prod = {9'h000, brt_q} * {9'h000, duty} + 17'd255;
  assign level = src_pulse ? duty :
                 host_only ? brt_q : prod[15:8];
  dim_link_if dl ();
  assign dl.on = backlight_status_flag_q;
  assign dl.direct = cfg_q[CFG_DIRECT_BIT];
  assign dl.equal = ph_q[PH_EQUAL_BIT];
  assign dl.level = level;
  assign dl.ps = ph_q[6:0];
  assign dl.active = mask_q & ~fault_s;
  channel_pwm_gen u_gen (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .dl(dl.use_side),
    .pulse_s(pulse_s),
    .ch_drive(ch_drive)
  );
  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_brt_locked;
    apply && pend_addr_q == BRT_ADDR && src_pulse |=> brt_q == $past(brt_q);
  endproperty
  a_brt_locked: assert property (p_brt_locked) else $error("brightness changed in pulse mode");
  property p_brt_store;
    wr_brt |=> brt_q == $past(pend_data_q) ##1 (ptr_q != BRT_ADDR || rdata == brt_q);
  endproperty
  a_brt_store: assert property (p_brt_store) else $error("brightness not stored");
  property p_off_dark;
    !on_bit |=> ##2 (ch_drive == 6'h00 && health == 6'h00 && !backlight_status_flag_q);
  endproperty
  a_off_dark: assert property (p_off_dark) else $error("backlight not off");
  property p_on_time;
    on_bit && !backlight_status_flag_q |-> on_cnt_q < 20'(BL_ON_LIMIT);
  endproperty
  a_on_time: assert property (p_on_time) else $error("backlight late");
  property p_src_pulse;
    src_pulse |-> level == duty;
  endproperty
  a_src_pulse: assert property (p_src_pulse) else $error("pulse source ignored");
  property p_host_only;
    host_only |-> level == brt_q;
  endproperty
  a_host_only: assert property (p_host_only) else $error("host level wrong");
  property p_prop;
    !src_pulse && !host_only && brt_q == 8'hff |-> level == duty;
  endproperty
  a_prop: assert property (p_prop) else $error("product level wrong");
  property p_late_apply;
    $changed(ctl_q) || $changed(cfg_q) |-> $past(apply);
  endproperty
  a_late_apply: assert property (p_late_apply) else $error("write applied early");
  property p_health;
    (health & ~mask_q) == 6'h00 && (vsc != 2'b00 || (health | short_s) == ((mask_q & ~fault_s
      & {6{backlight_status_flag_q}}) | short_s));
  endproperty
  a_health: assert property (p_health) else $error("health readout wrong");
  property p_ack_addr;
    state_q == S_ADDR && byte_done && !start_ev && !stop_ev && sh_q[7:1] == DEV_ADDR
      |=> sda_oe [*1] ##0 state_q == S_AACK;
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("address not acknowledged");
  c_bl_on: cover property ($rose(backlight_status_flag_q));
  c_read: cover property (state_q == S_RD && byte_done);
  c_prop: cover property (wr_brt && !host_only);
endmodule // backlight_dimming_control
`default_nettype wire

// ===== tb/smbus_host_model.sv
// Purpose: Two-wire host model that issues byte writes and byte reads
// Assumes: Open-drain data line with pull-up, host owns the clock line
// Notes: High phase of the clock line lasts 10 core cycles, low phase 11
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  // Clock
  input wire logic core_clk,
  // Two-wire pins
  output logic scl,
  output logic sda_low,
  input wire logic sda_line,
  // Read results
  output logic [7:0] rd_data,
  output logic rd_done,
  output logic nack_seen
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_data = 8'h00;
    rd_done = 1'b0;
    nack_seen = 1'b0;
  end
  // ==========================================================
  // Bus phases
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic start_cond();
    sda_low <= 1'b0;
    tick(10);
    scl <= 1'b1;
    tick(10);
    sda_low <= 1'b1;
    tick(10);
    scl <= 1'b0;
    tick(1);
  endtask
  task automatic stop_cond();
    sda_low <= 1'b1;
    tick(10);
    scl <= 1'b1;
    tick(10);
    sda_low <= 1'b0;
    tick(20);
  endtask
  // Nine bits; a 1 releases the line so the device may answer
  task automatic xfer(input logic [8:0] v, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      sda_low <= !v[i];
      tick(10);
      scl <= 1'b1;
      tick(10);
      r[i] = sda_line;
      scl <= 1'b0;
      tick(1);
    end
    if (r[0] !== 1'b0) begin
      nack_seen <= 1'b1;
    end
  endtask
  // ==========================================================
  // Register transactions
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
    logic [8:0] r;
    nack_seen <= 1'b0;
    start_cond();
    xfer({dev, 1'b0, 1'b1}, r);
    xfer({a, 1'b1}, r);
    xfer({d, 1'b1}, r);
    stop_cond();
  endtask
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] a);
    logic [8:0] r;
    logic [8:0] q;
    nack_seen <= 1'b0;
    start_cond();
    xfer({dev, 1'b0, 1'b1}, r);
    xfer({a, 1'b1}, r);
    start_cond();
    xfer({dev, 1'b1, 1'b1}, r);
    // Host nack ends the read
    xfer(9'h1ff, q);
    stop_cond();
    rd_data <= q[8:1];
    rd_done <= 1'b1;
    tick(1);
    rd_done <= 1'b0;
  endtask
endmodule // smbus_host_model
`default_nettype wire

// ===== tb/backlight_dimming_control_test.sv
// Purpose: Self-checking bench of the backlight register bank
// Assumes: Host model on the two-wire link, bench drives the analog status
// Notes: Short on-delay and duty window parameters keep the run brief
`timescale 1ns/1ps
`default_nettype none
module backlight_dimming_control_test;
  import backlight_pkg::*;
  localparam logic [6:0] DEV = 7'h2c;
  localparam int BL_LIM = 20;
  logic core_clk, rst_n, ext_pulse, scl, host_low, sda_out, sda_oe, rd_done, nack_seen;
  logic boost_enable, status_flag, freq_sel;
  logic [1:0] thr_sel;
  logic [5:0] ch_fault, ch_short, ch_drive;
  logic [7:0] rd_data, v;
  logic [7:0] exp_q[$];
  int mismatches, n_tests, cycles, seed;
  wire logic sda_line = !(host_low || (sda_oe && !sda_out));
  // ==========================================================
  // Design and host
  backlight_dimming_control #(.DEV_ADDR(DEV), .BL_ON_LIMIT(BL_LIM), .DUTY_LOG(2)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .external_pulse_input(ext_pulse),
    .ch_fault(ch_fault), .ch_short(ch_short), .ch_drive(ch_drive),
    .boost_enable(boost_enable), .backlight_status_flag(status_flag),
    .switching_freq_select(freq_sel), .short_threshold_select(thr_sel));
  smbus_host_model i_host (
    .core_clk(core_clk), .scl(scl), .sda_low(host_low), .sda_line(sda_line),
    .rd_data(rd_data), .rd_done(rd_done), .nack_seen(nack_seen));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = !core_clk;
  end
  // ==========================================================
  // Checking
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Read results come back in request order
  always @(posedge core_clk) begin
    if (rd_done === 1'b1) begin
      check("register read", exp_q.pop_front(), rd_data);
    end
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 95000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.write_reg(DEV, a, d);
    check("write ack", 8'h00, {7'h00, nack_seen});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.read_reg(DEV, a);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    ext_pulse = 1'b0;
    ch_fault = 6'h00;
    ch_short = 6'h00;
    seed = 32'h66a3;
    wait_cyc(8);
    rst_n <= 1'b1;
    wait_cyc(4);
    check("freq select", 8'h01, {7'h00, freq_sel});
    check("short threshold", 8'h03, {6'h00, thr_sel});
    rd(BRT_ADDR, 8'hff);
    rd(CTL_ADDR, 8'h00);
    rd(CFG_ADDR, CFG_RESET);
    rd(PHASE_ADDR, PHASE_RESET);
    rd(MASK_ADDR, 8'h00);
    wr(BRT_ADDR, 8'h40);
    rd(BRT_ADDR, 8'h40);
    // Wrong slave address is not answered and changes nothing
    i_host.write_reg(7'h2d, BRT_ADDR, 8'h12);
    check("nack", 8'h01, {7'h00, nack_seen});
    rd(BRT_ADDR, 8'h40);
    wr(CTL_ADDR, 8'h05);
    check("boost", 8'h01, {7'h00, boost_enable});
    wait_cyc(BL_LIM + 5);
    check("status", 8'h01, {7'h00, status_flag});
    rd(MASK_ADDR, 8'h3f);
    for (int i = 0; i < 3; i++) begin
      v = 8'($random(seed));
      wr(BRT_ADDR, v);
      rd(BRT_ADDR, v);
    end
    wr(BRT_ADDR, 8'hff);
    wait_cyc(20);
    check("drive full", 8'h3f, {2'b00, ch_drive});
    wr(BRT_ADDR, 8'h00);
    wait_cyc(20);
    check("drive zero code", 8'h00, {2'b00, ch_drive});
    ch_fault <= 6'h04;
    ch_short <= 6'h01;
    wait_cyc(10);
    rd(MASK_ADDR, 8'h3a);
    wr(CFG_ADDR, 8'h18);
    check("freq select", 8'h00, {7'h00, freq_sel});
    check("short threshold", 8'h00, {6'h00, thr_sel});
    rd(MASK_ADDR, 8'h3b);
    ch_fault <= 6'h00;
    ch_short <= 6'h00;
    wr(MASK_ADDR, 8'h0f);
    rd(MASK_ADDR, 8'h0f);
    wr(MASK_ADDR, 8'h3f);
    // Reserved bits plus external source
    wr(CTL_ADDR, 8'hf7);
    rd(CTL_ADDR, 8'hf7);
    wr(BRT_ADDR, 8'h22);
    rd(BRT_ADDR, 8'h00);
    ext_pulse <= 1'b1;
    wait_cyc(2500);
    check("drive pulse high", 8'h3f, {2'b00, ch_drive});
    ext_pulse <= 1'b0;
    wait_cyc(2500);
    check("drive pulse low", 8'h00, {2'b00, ch_drive});
    // Off bit clear overrides the mode bits
    wr(CTL_ADDR, 8'h06);
    wait_cyc(3);
    check("boost off", 8'h00, {7'h00, boost_enable});
    check("status off", 8'h00, {7'h00, status_flag});
    check("drive off", 8'h00, {2'b00, ch_drive});
    rd(MASK_ADDR, 8'h00);
    wr(8'h05, 8'h55);
    rd(8'h05, 8'h00);
    // Direct mode with bits 5..3 as software must set them
    wr(CTL_ADDR, 8'h01);
    wr(CFG_ADDR, 8'h9b);
    ext_pulse <= 1'b1;
    wait_cyc(12000);
    check("direct high", 8'h3f, {2'b00, ch_drive});
    ext_pulse <= 1'b0;
    wait_cyc(12000);
    check("direct low", 8'h00, {2'b00, ch_drive});
    wait_cyc(2);
    report_and_stop();
  end
endmodule // backlight_dimming_control_test
`default_nettype wire
